/* File: src/tcu_pkg.sv */
// Constants, field layout and state carrier for the 16-bit timer slice
package tcu_pkg;

  // ==========================================================
  // Register offsets (8-bit I/O locations)
  localparam logic [7:0] ADDR_CTRL_A = 8'hA0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hA1;
  localparam logic [7:0] ADDR_CTRL_C = 8'hA2;
  localparam logic [7:0] ADDR_CNT    = 8'hA4;
  localparam logic [7:0] ADDR_CAP    = 8'hA6;
  localparam logic [7:0] ADDR_CMPA   = 8'hA8;
  localparam logic [7:0] HI_OFS      = 8'h01;

  // ==========================================================
  // Field positions
  localparam int unsigned B_NOISE = 7;
  localparam int unsigned B_EDGE  = 6;
  localparam int unsigned B_RSVD  = 5;
  localparam int unsigned B_WGM3  = 4;
  localparam int unsigned B_WGM2  = 3;
  localparam int unsigned C_FOCA  = 7;
  localparam int unsigned C_FOCB  = 6;
  localparam int unsigned A_COMA  = 6;
  localparam int unsigned A_COMB  = 4;
  localparam int unsigned A_ACOMP = 2;

  // ==========================================================
  // Clock select and output mode codes
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_D256  = 3'h4;
  localparam logic [2:0] CS_D1024 = 3'h5;
  localparam logic [2:0] CS_EXTF  = 3'h6;
  localparam logic [2:0] CS_EXTR  = 3'h7;
  localparam logic [1:0] COM_OFF  = 2'h0;
  localparam logic [1:0] COM_TOG  = 2'h1;
  localparam logic [1:0] COM_CLR  = 2'h2;
  localparam logic [1:0] COM_SET  = 2'h3;

  // Prescaler terminal masks
  localparam logic [9:0] PRE_M8    = 10'h007;
  localparam logic [9:0] PRE_M64   = 10'h03F;
  localparam logic [9:0] PRE_M256  = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;

  // ==========================================================
  // Waveform mode sets, one bit per mode number
  localparam logic [15:0] M_PC      = 16'h0F0E;
  localparam logic [15:0] M_FAST    = 16'hC0E0;
  localparam logic [15:0] M_NONPWM  = 16'h1011;
  localparam logic [15:0] M_CAPTOP  = 16'h5500;
  localparam logic [15:0] M_CMPTOP  = 16'h8A10;
  localparam logic [15:0] M_TOP8    = 16'h0022;
  localparam logic [15:0] M_TOP9    = 16'h0044;
  localparam logic [15:0] M_TOP10   = 16'h0088;
  localparam logic [15:0] M_PCTOG   = 16'h0A00;
  localparam logic [15:0] M_FASTTOG = 16'h8000;
  localparam logic [3:0]  WGM_CTCA  = 4'h4;

  localparam logic [15:0] TOP_8   = 16'h00FF;
  localparam logic [15:0] TOP_9   = 16'h01FF;
  localparam logic [15:0] TOP_10  = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [3:0]  FILT_ONES = 4'hF;
  localparam logic [3:0]  FILT_ZERO = 4'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcu_bus_t;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [15:0] cmpa;
    logic [7:0]  temp;
    logic [7:0]  rdata;
    logic [9:0]  pre;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        cap_s1;
    logic        cap_s2;
    logic        ac_s1;
    logic        ac_s2;
    logic [3:0]  sr;
    logic        filt;
    logic        edge_prev;
    logic        down;
    logic        blk;
    logic        flag;
    logic        match;
    logic        out_a;
    logic        out_b;
  } tcu_state_t;

  // Non-PWM compare action on an output
  function automatic logic com_apply(input logic [1:0] com, input logic cur);
    case (com)
      COM_TOG: com_apply = ~cur;
      COM_CLR: com_apply = 1'b0;
      COM_SET: com_apply = 1'b1;
      default: com_apply = cur;
    endcase
  endfunction : com_apply

endpackage : tcu_pkg

/* File: src/tcu_timer.sv */
// 16-bit timer/counter with capture, compare A and forced compares
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

module tcu_timer
  import tcu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire tcu_bus_t   bus,
  output logic [7:0]      rdata,
  input  wire logic       ext_clock_pin,
  input  wire logic       capture_input_pin,
  input  wire logic       acomp_in,
  input  wire logic       capture_flag_clr,
  output logic            capture_flag,
  output logic            compare_a_match,
  output logic            compare_out_a,
  output logic            compare_out_b
);

  // ==========================================================
  // State and decode
  tcu_state_t s;
  tcu_state_t n;
  logic [3:0]  waveform_mode;
  logic [2:0]  clock_sel;
  logic [1:0]  mode_a;
  logic [1:0]  mode_b;
  logic [15:0] top;
  logic        is_pc;
  logic        is_fast;
  logic        non_pwm;
  logic        cap_top;
  logic        tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_cur;
  logic        trig;
  logic        hit;
  logic        wr_cnt;
  logic        wr_foc;

  // Mode fields split across the two control registers
  assign waveform_mode = {s.ctrl_b[B_WGM3:B_WGM2], s.ctrl_a[1:0]};
  assign clock_sel     = s.ctrl_b[2:0];
  assign mode_a        = s.ctrl_a[A_COMA +: 2];
  assign mode_b        = s.ctrl_a[A_COMB +: 2];
  assign is_pc         = M_PC[waveform_mode];
  assign is_fast       = M_FAST[waveform_mode];
  assign non_pwm       = M_NONPWM[waveform_mode];
  assign cap_top       = M_CAPTOP[waveform_mode];
  assign wr_cnt        = bus.wr && (bus.addr == ADDR_CNT);
  assign wr_foc        = bus.wr && (bus.addr == ADDR_CTRL_C);

  // Top value per mode; reserved mode counts as normal, compare outputs never change
  assign top = cap_top                   ? s.cap :
               M_CMPTOP[waveform_mode]  ? s.cmpa :
               M_TOP8[waveform_mode]    ? TOP_8 :
               M_TOP9[waveform_mode]    ? TOP_9 :
               M_TOP10[waveform_mode]   ? TOP_10 : TOP_MAX;

  // Edge detect on the synchronised pin, never on the first stage
  assign ext_rise = s.ext_s2 & ~s.ext_prev;
  assign ext_fall = ~s.ext_s2 & s.ext_prev;

  // Clock source select
  always_comb begin
    case (clock_sel)
      CS_STOP:  tick = 1'b0;
      CS_DIV1:  tick = 1'b1;
      CS_DIV8:  tick = (s.pre & PRE_M8) == PRE_M8;
      CS_DIV64: tick = (s.pre & PRE_M64) == PRE_M64;
      CS_D256:  tick = (s.pre & PRE_M256) == PRE_M256;
      CS_D1024: tick = s.pre == PRE_M1024;
      CS_EXTF:  tick = ext_fall;
      CS_EXTR:  tick = ext_rise;
      default:  tick = 1'b0;
    endcase
  end

  // Filtered or raw capture level, then the selected edge
  assign cap_cur = s.ctrl_b[B_NOISE] ? s.filt : s.sr[0];
  assign trig    = !cap_top && (s.ctrl_b[B_EDGE] ?
                   (cap_cur & ~s.edge_prev) :
                   (~cap_cur & s.edge_prev));

  // Compare unit A, masked on the tick after a counter write
  assign hit = tick && !s.blk && (s.cnt == s.cmpa);

  // ==========================================================
  // Next-state logic
  always_comb begin
    n       = s;
    n.match = 1'b0;
    n.rdata = '0;

    // Two-stage synchronisers for all pins
    n.ext_s1   = ext_clock_pin;
    n.ext_s2   = s.ext_s1;
    n.ext_prev = s.ext_s2;
    n.cap_s1   = capture_input_pin;
    n.cap_s2   = s.cap_s1;
    n.ac_s1    = acomp_in;
    n.ac_s2    = s.ac_s1;

    // Sample history; third flop on from the pin
    n.sr = {s.sr[2:0], s.ctrl_a[A_ACOMP] ? s.ac_s2 : s.cap_s2};
    if (s.sr == FILT_ONES) begin
      n.filt = 1'b1;
    end else if (s.sr == FILT_ZERO) begin
      n.filt = 1'b0;
    end
    n.edge_prev = cap_cur;

    // Free prescaler, held cleared while stopped
    n.pre = (clock_sel == CS_STOP) ? '0 : s.pre + 10'h001;

    // Counting sequence and waveform outputs
    if (tick) begin
      n.blk   = 1'b0;
      n.match = hit;
      if (is_pc) begin
        if (s.down) begin
          if (s.cnt == CNT_ZERO) begin
            n.down = 1'b0;
            n.cnt  = s.cnt + CNT_ONE;
          end else begin
            n.cnt = s.cnt - CNT_ONE;
          end
        end else if (s.cnt >= top) begin
          n.down = 1'b1;
          n.cnt  = s.cnt - CNT_ONE;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end else begin
        n.down = 1'b0;
        n.cnt  = (s.cnt == top) ? CNT_ZERO : s.cnt + CNT_ONE;
      end
      // Fast PWM restores the output at bottom
      if (is_fast && (s.cnt == top)) begin
        if (mode_a == COM_CLR) begin
          n.out_a = 1'b1;
        end else if (mode_a == COM_SET) begin
          n.out_a = 1'b0;
        end
      end
      if (hit) begin
        if (non_pwm) begin
          n.out_a = com_apply(mode_a, s.out_a);
        end else if (is_fast) begin
          case (mode_a)
            COM_TOG: n.out_a = M_FASTTOG[waveform_mode] ? ~s.out_a : s.out_a;
            COM_CLR: n.out_a = 1'b0;
            COM_SET: n.out_a = 1'b1;
            default: n.out_a = s.out_a;
          endcase
        end else if (is_pc) begin
          case (mode_a)
            COM_TOG: n.out_a = M_PCTOG[waveform_mode] ? ~s.out_a : s.out_a;
            COM_CLR: n.out_a = s.down;
            COM_SET: n.out_a = ~s.down;
            default: n.out_a = s.out_a;
          endcase
        end
      end
    end

    // Register reads, one cycle latency; low byte loads the latch
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL_A: n.rdata = s.ctrl_a;
        ADDR_CTRL_B: n.rdata = s.ctrl_b;
        ADDR_CTRL_C: n.rdata = '0;
        ADDR_CNT: begin
          n.rdata = s.cnt[7:0];
          n.temp  = s.cnt[15:8];
        end
        ADDR_CAP: begin
          n.rdata = s.cap[7:0];
          n.temp  = s.cap[15:8];
        end
        ADDR_CMPA: begin
          n.rdata = s.cmpa[7:0];
          n.temp  = s.cmpa[15:8];
        end
        ADDR_CNT + HI_OFS:  n.rdata = s.temp;
        ADDR_CAP + HI_OFS:  n.rdata = s.temp;
        ADDR_CMPA + HI_OFS: n.rdata = s.temp;
        default: n.rdata = '0;
      endcase
    end

    // Register writes; high byte parks in the latch
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL_A: n.ctrl_a = bus.wdata;
        ADDR_CTRL_B: begin
          n.ctrl_b         = bus.wdata;
          n.ctrl_b[B_RSVD] = 1'b0;
        end
        ADDR_CTRL_C: begin
          // Strobes only: no flag, no counter clear
          if (non_pwm && bus.wdata[C_FOCA]) begin
            n.out_a = com_apply(mode_a, s.out_a);
          end
          if (non_pwm && bus.wdata[C_FOCB]) begin
            n.out_b = com_apply(mode_b, s.out_b);
          end
        end
        ADDR_CNT: begin
          n.cnt = {s.temp, bus.wdata};
          n.blk = 1'b1;
        end
        ADDR_CAP:  n.cap  = {s.temp, bus.wdata};
        ADDR_CMPA: n.cmpa = {s.temp, bus.wdata};
        ADDR_CNT + HI_OFS:  n.temp = bus.wdata;
        ADDR_CAP + HI_OFS:  n.temp = bus.wdata;
        ADDR_CMPA + HI_OFS: n.temp = bus.wdata;
        default: n.temp = s.temp;
      endcase
    end

    // Capture beats a same-cycle software write; set beats clear
    if (trig) begin
      n.cap = s.cnt;
    end
    n.flag = (s.flag & ~capture_flag_clr) | trig;
  end

  // Whole state in one register; reset clears all of it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rdata           = s.rdata;
  assign capture_flag    = s.flag;
  assign compare_a_match = s.match;
  assign compare_out_a   = s.out_a;
  assign compare_out_b   = s.out_b;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence filt_rise_s;
    $rose(s.sr[0]) ##1 s.sr[0] [*3];
  endsequence

  sequence cnt_wr_tick_s;
    wr_cnt ##1 (tick && !wr_cnt);
  endsequence

  filt_change_a: assert property ($changed(s.filt) |->
    ($past(s.sr) == FILT_ONES) || ($past(s.sr) == FILT_ZERO))
    else $error("filter changed without four equal samples");

  filt_delay_a: assert property (s.ctrl_b[B_NOISE] && !s.filt
    && !bus.wr ##0 filt_rise_s |=> s.filt)
    else $error("filtered input not high four cycles after raw");

  fall_capture_a: assert property (!s.ctrl_b[B_NOISE]
    && !s.ctrl_b[B_EDGE] && !cap_top && $fell(s.sr[0]) |=> s.flag)
    else $error("falling edge did not set capture flag");

  cap_copy_a: assert property (trig |=> s.cap == $past(s.cnt))
    else $error("capture register missed counter value");

  cap_off_a: assert property (cap_top && !bus.wr |=> $stable(s.cap))
    else $error("capture occurred while capture value is top");

  stop_hold_a: assert property (clock_sel == CS_STOP && !wr_cnt
    |=> $stable(s.cnt))
    else $error("counter moved while stopped");

  force_ignore_a: assert property (wr_foc && !non_pwm && !tick
    |=> $stable(s.out_a) && $stable(s.out_b))
    else $error("force strobe acted in a PWM mode");

  force_set_a: assert property (wr_foc && non_pwm
    && bus.wdata[C_FOCA] && mode_a == COM_SET |=> s.out_a)
    else $error("forced compare did not set output");

  force_quiet_a: assert property (wr_foc && !tick && !trig
    |=> $stable(s.cnt) && !s.match
    && s.flag == ($past(s.flag) & ~$past(capture_flag_clr)))
    else $error("force strobe touched counter or flags");

  foc_read_a: assert property (bus.rd && bus.addr == ADDR_CTRL_C
    |=> rdata == 8'h00)
    else $error("force bits read back nonzero");

  match_block_a: assert property (cnt_wr_tick_s |=> !s.match)
    else $error("compare match not blocked after counter write");

  ctc_wrap_a: assert property (tick && waveform_mode == WGM_CTCA
    && s.cnt == s.cmpa && !wr_cnt |=> s.cnt == CNT_ZERO)
    else $error("clear-on-match did not clear counter");

  // ==========================================================
  // Capture edge and flag checks
  // Control held steady so the edge register saw the raw level last cycle
  rise_capture_a: assert property (!s.ctrl_b[B_NOISE]
    && s.ctrl_b[B_EDGE] && !cap_top && $stable(s.ctrl_b) && $rose(s.sr[0]) |=> s.flag)
    else $error("rising edge did not set capture flag");

  flag_sticky_a: assert property (s.flag && !capture_flag_clr
    |=> s.flag)
    else $error("capture flag dropped without a clear");

  // ==========================================================
  // Counting source checks
  div1_step_a: assert property (clock_sel == CS_DIV1 && !wr_cnt
    && !is_pc && s.cnt != top |=> s.cnt == $past(s.cnt) + CNT_ONE)
    else $error("undivided clock did not advance counter");

  div8_hold_a: assert property (clock_sel == CS_DIV8 && !wr_cnt
    && (s.pre & PRE_M8) != PRE_M8 |=> $stable(s.cnt))
    else $error("divide by eight counted between taps");

  ext_rise_hold_a: assert property (clock_sel == CS_EXTR
    && !ext_rise && !wr_cnt |=> $stable(s.cnt))
    else $error("counter moved without a rising pin edge");

  ext_fall_hold_a: assert property (clock_sel == CS_EXTF
    && !ext_fall && !wr_cnt |=> $stable(s.cnt))
    else $error("counter moved without a falling pin edge");

  // ==========================================================
  // Byte access and compare checks
  cnt_commit_a: assert property (wr_cnt
    |=> s.cnt == {$past(s.temp), $past(bus.wdata)})
    else $error("counter write did not commit latch and low byte");

  hi_latch_a: assert property (bus.rd
    && bus.addr == ADDR_CNT + HI_OFS |=> rdata == $past(s.temp))
    else $error("high byte read did not return the latch");

  match_pulse_a: assert property (hit |=> s.match)
    else $error("compare hit gave no match pulse");

  pc_clear_a: assert property (hit && is_pc
    && mode_a == COM_CLR && !s.down |=> !s.out_a)
    else $error("phase-correct match while up did not clear output");

endmodule : tcu_timer

/* File: bench/tcu_timer_tb_top.sv */
// Self-checking testbench for the 16-bit timer slice
`timescale 1ns/1ps

module tcu_timer_tb_top
  import tcu_pkg::*;
;
  // ==========================================================
  // Signals
  logic        clk_sys;
  logic        arst_n;
  tcu_bus_t    bus;
  logic [7:0]  rdata;
  logic        ext_clock_pin;
  logic        capture_input_pin;
  logic        acomp_in;
  logic        capture_flag_clr;
  logic        capture_flag;
  logic        compare_a_match;
  logic        compare_out_a;
  logic        compare_out_b;
  int          n_mismatch;
  int          checked;
  int          cycles = 0;
  logic [15:0] v;
  logic [7:0]  b;
  int          divs[5] = '{1, 8, 64, 256, 1024};

  tcu_timer DUT (
    .clk_sys           (clk_sys),
    .arst_n            (arst_n),
    .bus               (bus),
    .rdata             (rdata),
    .ext_clock_pin     (ext_clock_pin),
    .capture_input_pin (capture_input_pin),
    .acomp_in          (acomp_in),
    .capture_flag_clr  (capture_flag_clr),
    .capture_flag      (capture_flag),
    .compare_a_match   (compare_a_match),
    .compare_out_a     (compare_out_a),
    .compare_out_b     (compare_out_b)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Whole run is about 14k cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  // ==========================================================
  // Bus and check tasks
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_sys);
    bus.wr    <= 1'b0;
  endtask : wr8

  // Read data stands only in the cycle after the strobe
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_sys);
    bus.rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd8

  // High byte first on write, low byte first on read
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr8(a + HI_OFS, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    rd8(a, lo);
    rd8(a + HI_OFS, hi);
    d = {hi, lo};
  endtask : rd16

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk16(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] got;
    rd16(a, got);
    chk(got, exp, "reg16");
  endtask : chk16

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_n

  task automatic set_pin(input logic val, input int n);
    @(posedge clk_sys);
    capture_input_pin <= val;
    wait_n(n);
  endtask : set_pin

  task automatic clr_flag();
    @(posedge clk_sys);
    capture_flag_clr <= 1'b1;
    @(posedge clk_sys);
    capture_flag_clr <= 1'b0;
    wait_n(1);
    chk(capture_flag, 1'b0, "flag clear");
  endtask : clr_flag

  // Force strobe: outputs checked against expected levels, no flag, no match pulse
  task automatic force_chk(input logic [7:0] ca, input logic [7:0] fc, input logic ea,
                           input logic eb);
    wr8(ADDR_CTRL_A, ca);
    wr8(ADDR_CTRL_C, fc);
    #1;
    chk(compare_out_a, ea, "out a");
    chk(compare_out_b, eb, "out b");
    chk(compare_a_match, 1'b0, "force match");
    chk(capture_flag, 1'b0, "force flag");
  endtask : force_chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    bus = '0;
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    acomp_in = 1'b0;
    capture_flag_clr = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset values, unmapped place included
    for (int i = 0; i < 10; i++) begin
      rd8(8'hA0 + 8'(i), b);
      chk(b, 8'h00, "reset");
    end
    wr8(8'hB0, 8'h5A);
    rd8(8'hB0, b);
    chk(b, 8'h00, "unmapped");
    // Reserved bit reads zero; ext rising clock idles with pin low
    wr8(ADDR_CTRL_B, 8'hFF);
    rd8(ADDR_CTRL_B, b);
    chk(b, 8'hDF, "ctrl b");
    wr8(ADDR_CTRL_B, 8'h00);
    // 16-bit read and write through the pair of byte locations
    wr16(ADDR_CAP, 16'hBEEF);
    wr16(ADDR_CMPA, 16'h1234);
    wr16(ADDR_CNT, 16'hA55A);
    chk16(ADDR_CAP, 16'hBEEF);
    chk16(ADDR_CMPA, 16'h1234);
    chk16(ADDR_CNT, 16'hA55A);
    // One latch for all pairs: high byte of one, low byte of another
    wr8(ADDR_CMPA + HI_OFS, 8'hAB);
    wr8(ADDR_CNT, 8'hCD);
    chk16(ADDR_CNT, 16'hABCD);
    chk16(ADDR_CMPA, 16'h1234);
    rd8(ADDR_CNT, b);
    rd8(ADDR_CAP + HI_OFS, b);
    chk(b, 8'hAB, "latch read");
    // Capture edges, counter parked at a known value
    wr16(ADDR_CNT, 16'h0777);
    set_pin(1'b1, 6);
    chk(capture_flag, 1'b0, "rise ignored");
    set_pin(1'b0, 6);
    chk(capture_flag, 1'b1, "fall capture");
    chk16(ADDR_CAP, 16'h0777);
    clr_flag();
    wr8(ADDR_CTRL_B, 8'h40);
    wr16(ADDR_CNT, 16'h0888);
    set_pin(1'b1, 6);
    chk(capture_flag, 1'b1, "rise capture");
    chk16(ADDR_CAP, 16'h0888);
    clr_flag();
    set_pin(1'b0, 6);
    chk(capture_flag, 1'b0, "fall ignored");
    // Filter: short glitch dropped, clean edge four cycles late
    wr8(ADDR_CTRL_B, 8'hC0);
    set_pin(1'b1, 2);
    set_pin(1'b0, 10);
    chk(capture_flag, 1'b0, "glitch");
    set_pin(1'b1, 6);
    chk(capture_flag, 1'b0, "filter early");
    wait_n(4);
    chk(capture_flag, 1'b1, "filter late");
    clr_flag();
    set_pin(1'b0, 10);
    // Comparator as alternate capture source
    wr8(ADDR_CTRL_A, 8'h04);
    wr8(ADDR_CTRL_B, 8'h40);
    @(posedge clk_sys);
    acomp_in <= 1'b1;
    wait_n(6);
    chk(capture_flag, 1'b1, "comparator");
    clr_flag();
    // Modes with capture value as top never capture
    for (int i = 0; i < 4; i++) begin
      v = 16'(8 + 2 * i);
      wr8(ADDR_CTRL_A, {6'h00, v[1:0]});
      wr8(ADDR_CTRL_B, {3'b000, v[3:2], 3'b000});
      set_pin(1'b1, 6);
      set_pin(1'b0, 6);
      chk(capture_flag, 1'b0, "capture top");
    end
    wr8(ADDR_CTRL_B, 8'h00);
    // Forced compares in non-PWM and PWM modes
    force_chk(8'hF0, 8'hC0, 1'b1, 1'b1);
    force_chk(8'hA0, 8'hC0, 1'b0, 1'b0);
    force_chk(8'h40, 8'h80, 1'b1, 1'b0);
    force_chk(8'h81, 8'h80, 1'b1, 1'b0);
    wr8(ADDR_CTRL_B, 8'h08);
    wr16(ADDR_CMPA, 16'h0055);
    wr16(ADDR_CNT, 16'h0055);
    force_chk(8'h40, 8'h80, 1'b0, 1'b0);
    chk16(ADDR_CNT, 16'h0055);
    rd8(ADDR_CTRL_C, b);
    chk(b, 8'h00, "ctrl c");
    // Running match, then a counter write blocks the next match
    wr8(ADDR_CTRL_A, 8'h00);
    wr16(ADDR_CMPA, 16'h0010);
    wr16(ADDR_CNT, 16'h0000);
    wr8(ADDR_CTRL_B, {5'h00, CS_DIV1});
    v = 16'h0000;
    for (int i = 0; i < 40 && v == 16'h0000; i++) begin
      wait_n(1);
      if (compare_a_match === 1'b1) v = 16'h0001;
    end
    chk(v, 16'h0001, "match seen");
    wait_n(1);
    chk(compare_a_match, 1'b0, "match pulse");
    wr16(ADDR_CNT, 16'h0010);
    v = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      #9;
      if (compare_a_match !== 1'b0) v = 16'h0001;
    end
    chk(v, 16'h0000, "blocked match");
    // Clear-on-match wraps at compare A; stop before writing the counter
    wr8(ADDR_CTRL_B, 8'h00);
    wr16(ADDR_CMPA, 16'h0008);
    wr16(ADDR_CNT, 16'h0000);
    wr8(ADDR_CTRL_B, {3'b000, 2'b01, CS_DIV1});
    wait_n(30);
    wr8(ADDR_CTRL_B, 8'h00);
    rd16(ADDR_CNT, v);
    chk(16'(v <= 16'h0008), 16'h0001, "ctc wrap");
    // Prescaler taps: about ten ticks each
    for (int i = 0; i < 5; i++) begin
      wr8(ADDR_CTRL_B, 8'h00);
      wr16(ADDR_CNT, 16'h0000);
      wr8(ADDR_CTRL_B, 8'(i + 1));
      wait_n(10 * divs[i]);
      wr8(ADDR_CTRL_B, 8'h00);
      rd16(ADDR_CNT, v);
      chk(16'(v >= 16'd9 && v <= 16'd13), 16'h0001, "prescale");
    end
    wait_n(50);
    chk16(ADDR_CNT, v);
    // External clock: five rising and four falling edges
    for (int cs = 6; cs < 8; cs++) begin
      wr16(ADDR_CNT, 16'h0000);
      wr8(ADDR_CTRL_B, 8'(cs));
      for (int k = 0; k < 9; k++) begin
        @(posedge clk_sys);
        ext_clock_pin <= (k % 2 == 0);
        wait_n(4);
      end
      wait_n(4);
      wr8(ADDR_CTRL_B, 8'h00);
      @(posedge clk_sys);
      ext_clock_pin <= 1'b0;
      chk16(ADDR_CNT, (cs == 7) ? 16'h0005 : 16'h0004);
    end
    finish_test();
  end

endmodule : tcu_timer_tb_top
